// File: cmae_alu.sv
// Eight-bit adder and subtractor with the five condition flags.
// Assumes operands arrive stable from the sequencer in the same cycle.
`timescale 1ns/1ps
`include "cmae_map.svh"
module cmae_alu (
  // Operands in, result and flags out.
  cmae_alu_if.alu alu_p
);
  import cmae_pkg::*;

  cmae_byte_t bx;
  logic       cx;
  logic [8:0] sum;
  logic [4:0] nib;

  // Subtraction adds the complement; the raw carry is inverted into borrow.
  always_comb begin
    bx  = alu_p.sub ? ~alu_p.b : alu_p.b;
    cx  = alu_p.sub ? ~alu_p.cin : alu_p.cin;
    sum = {1'b0, alu_p.a} + {1'b0, bx} + {8'h00, cx};
    nib = {1'b0, alu_p.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
    alu_p.res       = sum[7:0];
    alu_p.fl.carry  = sum[8] ^ alu_p.sub;
    alu_p.fl.half   = nib[4];
    alu_p.fl.zero   = (sum[7:0] == `CMAE_BYTE_RESET);
    alu_p.fl.sign   = sum[7];
    alu_p.fl.parity = ~^sum[7:0];
  end
endmodule

// File: cmae_alu_if.sv
// Operand and result bundle between the sequencer and the byte adder.
// Assumes the package is compiled first.
`timescale 1ns/1ps
interface cmae_alu_if;
  import cmae_pkg::*;
  cmae_byte_t  a;
  cmae_byte_t  b;
  logic        cin;
  logic        sub;
  cmae_byte_t  res;
  cmae_flags_t fl;
  modport ctl (output a, b, cin, sub, input res, fl);
  modport alu (input a, b, cin, sub, output res, fl);
endinterface

// File: cmae_exec.sv
// Execution sequencer for the move, load, store and byte arithmetic groups.
// Assumes a memory that answers a read by the third state of its cycle.
//
// Overview of operation
// RL1: Data movement never changes any flag.
// RL2: Register copy moves source into destination.
// RL3: Pointer-addressed copies take two cycles, seven states.
// RL4: Immediate load: register seven states, memory ten.
// RL5: Pair immediate: byte three high, byte two low.
// RL6: Direct accumulator load/store: thirteen states.
// RL7: Direct pointer load/store: low, then address+1.
// RL8: Indirect accumulator access uses only first pairs.
// RL9: Swap exchanges pointer pair with second pair.
// RL10: Arithmetic updates zero, sign, parity, carry, half.
// RL11: Subtraction is two's complement; carry means borrow.
// RL12: Add: register four states, memory/immediate seven.
// RL13: Add-with-carry also adds the carry flag.
// RL14: Subtract stores the difference in the accumulator.
// RL15: Subtract-with-borrow also subtracts the carry flag.
// RL16: Byte increment keeps carry; register five states.
// RL17: Byte decrement mirrors increment flags and timing.
// RL18: Pair increment carries into high, no flags.
// RL19: Register select: 111 accumulator, 000-101 general.
// RL20: Pair select: 00, 01, pointer 10, stack 11.
// RL21: Parity flag set for even one count.
// RL22: Half carry is carry out of bit three.
// RL23: Operand accesses follow the instruction byte fetches.
`timescale 1ns/1ps
`include "cmae_map.svh"
module cmae_exec #(
  parameter int STATE_DIV = 1
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Run control.
  input  wire logic                 run,
  // Memory bus.
  output cmae_pkg::cmae_word_t      mem_addr_q,
  output logic                      mem_rd_q,
  output logic                      mem_wr_q,
  output cmae_pkg::cmae_byte_t      mem_wdata_q,
  input  wire cmae_pkg::cmae_byte_t mem_rdata,
  // Processor state.
  output cmae_pkg::cmae_word_t      pc_q,
  output cmae_pkg::cmae_word_t      sp_q,
  output cmae_pkg::cmae_byte_t      regs_q [8],
  output cmae_pkg::cmae_flags_t     flags_q,
  output logic                      done_q,
  output logic                      stop_q
);
  import cmae_pkg::*;

  cmae_state_t st_q;
  logic [2:0]  mc_q;
  logic [2:0]  t_q;
  cmae_byte_t  ir_q;
  cmae_byte_t  b2_q;
  cmae_byte_t  b3_q;
  cmae_byte_t  tmp_q;
  logic        tick;
  cmae_kind_t  kind;
  logic [2:0]  dsel;
  logic [2:0]  ssel;
  logic [1:0]  psel;
  logic [2:0]  last_t;
  logic        end_cyc;
  logic        end_instr;
  cmae_word_t  hl;
  cmae_word_t  direct;
  cmae_word_t  pair_inc;
  cmae_word_t  plan_addr;
  logic        plan_rd;
  logic        plan_wr;
  logic        plan_imm;
  cmae_byte_t  plan_wdata;

  cmae_alu_if alu_if ();

  if (STATE_DIV < 1) begin : g_bad_div
    $error("The state divider must be at least one.");
  end

  cmae_state_tick #(.DIV(STATE_DIV)) u_tick (
    .clk  (clk),
    .nrst (nrst),
    .tick (tick)
  );

  cmae_alu u_alu (
    .alu_p (alu_if.alu)
  );

  // Classifies an opcode; anything outside these groups stops the block.
  function automatic cmae_kind_t kind_of(input cmae_byte_t op);
    cmae_kind_t k;
    logic [2:0] d;
    logic [2:0] s;
    d = op[`CMAE_DST_MSB:`CMAE_DST_LSB];
    s = op[`CMAE_SRC_MSB:`CMAE_SRC_LSB];
    k = K_BAD;
    case (op[`CMAE_GRP_MSB:`CMAE_GRP_LSB])
      `CMAE_GRP_COPY: begin
        if (d == `CMAE_SEL_MEM && s == `CMAE_SEL_MEM) k = K_BAD;
        else if (s == `CMAE_SEL_MEM) k = K_COPY_RM;
        else if (d == `CMAE_SEL_MEM) k = K_COPY_MR;
        else k = K_COPY_RR;
      end
      `CMAE_GRP_ARITH: begin
        if (d <= `CMAE_AOP_LAST)
          k = (s == `CMAE_SEL_MEM) ? K_ARITH_M : K_ARITH_R;
      end
      `CMAE_GRP_IMM: begin
        if (op == `CMAE_OP_SWAP) k = K_SWAP;
        else if (s == `CMAE_LO_IMM && d <= `CMAE_AOP_LAST) k = K_ARITH_I;
      end
      default: begin
        case (s)
          `CMAE_LO_PAIR_IMM: if (!op[`CMAE_LOAD_BIT]) k = K_PAIR_IMM;
          `CMAE_LO_PAIR_INC: if (!op[`CMAE_LOAD_BIT]) k = K_PAIR_INC;
          `CMAE_LO_INC, `CMAE_LO_DEC:
            k = (d == `CMAE_SEL_MEM) ? K_STEP_M : K_STEP_R;
          `CMAE_LO_IMM: k = (d == `CMAE_SEL_MEM) ? K_IMM_M : K_IMM_R;
          `CMAE_LO_XFER: begin
            // RL8 indirect pair only
            if (!op[`CMAE_DIRECT_BIT])
              k = op[`CMAE_LOAD_BIT] ? K_ACC_LD_IND : K_ACC_ST_IND;
            else if (op[`CMAE_WIDE_BIT])
              k = op[`CMAE_LOAD_BIT] ? K_ACC_LD_DIR : K_ACC_ST_DIR;
            else
              k = op[`CMAE_LOAD_BIT] ? K_PTR_LD_DIR : K_PTR_ST_DIR;
          end
          default: k = K_BAD;
        endcase
      end
    endcase
    return k;
  endfunction

  // Index of the final machine cycle of each kind.
  function automatic logic [2:0] last_mc(input cmae_kind_t k);
    case (k)
      K_COPY_RM, K_COPY_MR, K_IMM_R, K_ACC_LD_IND, K_ACC_ST_IND,
      K_ARITH_M, K_ARITH_I:                return `CMAE_MC_2;
      K_IMM_M, K_PAIR_IMM, K_STEP_M:       return `CMAE_MC_3;
      K_ACC_LD_DIR, K_ACC_ST_DIR:          return `CMAE_MC_4;
      K_PTR_LD_DIR, K_PTR_ST_DIR:          return `CMAE_MC_5;
      default:                             return `CMAE_MC_1;
    endcase
  endfunction

  // RL20 pair decode
  function automatic cmae_word_t pair_get(input logic [1:0] rp);
    if (rp == `CMAE_PAIR_SP) return sp_q;
    return {regs_q[{rp, 1'b0}], regs_q[{rp, 1'b1}]};
  endfunction

  // Decoded fields of the held opcode.
  assign kind     = kind_of(ir_q);
  assign dsel     = ir_q[`CMAE_DST_MSB:`CMAE_DST_LSB];
  assign ssel     = ir_q[`CMAE_SRC_MSB:`CMAE_SRC_LSB];
  assign psel     = ir_q[`CMAE_PAIR_MSB:`CMAE_PAIR_LSB];
  always_comb hl = pair_get(`CMAE_PAIR_HL);
  assign direct   = {b3_q, b2_q};
  // RL18 pair carry
  always_comb pair_inc = pair_get(psel) + `CMAE_WORD_ONE;

  // RL16 RL17 five-state first cycle
  always_comb begin
    if (st_q == ST_FETCH && t_q > `CMAE_T_OPCODE &&
        (kind == K_COPY_RR || kind == K_STEP_R || kind == K_PAIR_INC))
      last_t = `CMAE_T_LONG_LAST;
    else if (st_q == ST_FETCH)
      last_t = `CMAE_T_M1_LAST;
    else
      last_t = `CMAE_T_MX_LAST;
  end

  assign end_cyc   = tick && t_q == last_t;
  assign end_instr = end_cyc && ((st_q == ST_FETCH) ?
                     last_mc(kind) == `CMAE_MC_1 : mc_q == last_mc(kind));

  // RL23 access plan per machine cycle
  always_comb begin
    plan_addr  = pc_q;
    plan_rd    = 1'b0;
    plan_wr    = 1'b0;
    plan_imm   = 1'b0;
    plan_wdata = `CMAE_BYTE_RESET;
    if (st_q == ST_FETCH) begin
      plan_rd = 1'b1;
    end else if (st_q == ST_OPER) begin
      case (kind)
        // RL3 pointer address
        K_COPY_RM, K_ARITH_M: begin
          plan_addr = hl;
          plan_rd   = 1'b1;
        end
        K_COPY_MR: begin
          plan_addr  = hl;
          plan_wr    = 1'b1;
          plan_wdata = regs_q[ssel];
        end
        K_IMM_R, K_ARITH_I, K_PAIR_IMM: begin
          plan_rd  = 1'b1;
          plan_imm = 1'b1;
        end
        // RL4 memory immediate
        K_IMM_M, K_STEP_M: begin
          plan_addr  = (kind == K_IMM_M && mc_q == `CMAE_MC_2) ? pc_q : hl;
          plan_imm   = kind == K_IMM_M && mc_q == `CMAE_MC_2;
          plan_rd    = mc_q == `CMAE_MC_2;
          plan_wr    = mc_q == `CMAE_MC_3;
          plan_wdata = (kind == K_IMM_M) ? b2_q : tmp_q;
        end
        // RL6 RL7 direct address
        K_ACC_LD_DIR, K_ACC_ST_DIR, K_PTR_LD_DIR, K_PTR_ST_DIR: begin
          plan_imm   = mc_q <= `CMAE_MC_3;
          plan_addr  = plan_imm ? pc_q :
                       (mc_q == `CMAE_MC_5) ? direct + `CMAE_WORD_ONE :
                       direct;
          plan_rd    = plan_imm || kind == K_ACC_LD_DIR ||
                       kind == K_PTR_LD_DIR;
          plan_wr    = !plan_rd;
          plan_wdata = (kind == K_ACC_ST_DIR) ? regs_q[`CMAE_SEL_ACC] :
                       (mc_q == `CMAE_MC_5) ? regs_q[`CMAE_SEL_H] :
                       regs_q[`CMAE_SEL_L];
        end
        // RL8 indirect pair address
        K_ACC_LD_IND, K_ACC_ST_IND: begin
          plan_addr  = pair_get(psel);
          plan_rd    = kind == K_ACC_LD_IND;
          plan_wr    = kind == K_ACC_ST_IND;
          plan_wdata = regs_q[`CMAE_SEL_ACC];
        end
        default: plan_rd = 1'b0;
      endcase
    end
  end

  // Bus outputs trail the plan by one clock; a write is a single pulse.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_addr_q  <= `CMAE_WORD_RESET;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= `CMAE_BYTE_RESET;
    end else begin
      mem_addr_q  <= plan_addr;
      mem_rd_q    <= plan_rd;
      mem_wr_q    <= plan_wr && tick && t_q == `CMAE_T_WRITE;
      mem_wdata_q <= plan_wdata;
    end
  end

  // Machine cycle and state sequencing.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      mc_q <= `CMAE_MC_1;
      t_q  <= `CMAE_T_FIRST;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (run) st_q <= ST_FETCH;
          mc_q <= `CMAE_MC_1;
          t_q  <= `CMAE_T_FIRST;
        end
        ST_FETCH, ST_OPER: begin
          if (end_cyc) begin
            t_q <= `CMAE_T_FIRST;
            if (st_q == ST_FETCH && kind == K_BAD) begin
              st_q <= ST_STOP;
            end else if (end_instr) begin
              st_q <= run ? ST_FETCH : ST_IDLE;
              mc_q <= `CMAE_MC_1;
            end else begin
              st_q <= ST_OPER;
              mc_q <= mc_q + 3'd1;
            end
          end else if (tick) begin
            t_q <= t_q + 3'd1;
          end
        end
        default: st_q <= ST_STOP;
      endcase
    end
  end

  // Opcode, immediate bytes and program counter.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ir_q <= `CMAE_BYTE_RESET;
      b2_q <= `CMAE_BYTE_RESET;
      b3_q <= `CMAE_BYTE_RESET;
      pc_q <= `CMAE_WORD_RESET;
    end else if (st_q == ST_FETCH && tick && t_q == `CMAE_T_OPCODE) begin
      ir_q <= mem_rdata;
      pc_q <= pc_q + `CMAE_WORD_ONE;
    end else if (st_q == ST_OPER && end_cyc && plan_imm) begin
      pc_q <= pc_q + `CMAE_WORD_ONE;
      if (mc_q == `CMAE_MC_2) b2_q <= mem_rdata;
      else b3_q <= mem_rdata;
    end
  end

  // Adder operands; steps add or subtract one from register or memory.
  always_comb begin
    if (kind == K_STEP_R || kind == K_STEP_M) begin
      alu_if.a   = (kind == K_STEP_M) ? mem_rdata : regs_q[dsel];
      alu_if.b   = `CMAE_BYTE_ONE;
      alu_if.cin = 1'b0;
      alu_if.sub = ir_q[`CMAE_DEC_BIT];
    end else begin
      // RL13 RL15 carry operand
      alu_if.a   = regs_q[`CMAE_SEL_ACC];
      alu_if.b   = (kind == K_ARITH_R) ? regs_q[ssel] : mem_rdata;
      alu_if.cin = dsel[`CMAE_AOP_CY_BIT] & flags_q.carry;
      // RL11 RL14 two's complement
      alu_if.sub = dsel[`CMAE_AOP_SUB_BIT];
    end
  end

  // Memory byte step result held for the write-back cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) tmp_q <= `CMAE_BYTE_RESET;
    else if (kind == K_STEP_M && end_cyc && mc_q == `CMAE_MC_2)
      tmp_q <= alu_if.res;
  end

  // RL1 RL10 flag updates
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= '0;
    end else if (end_instr &&
                 (kind == K_ARITH_R || kind == K_ARITH_M ||
                  kind == K_ARITH_I)) begin
      // RL21 RL22 adder flags
      flags_q <= alu_if.fl;
    end else if ((end_instr && kind == K_STEP_R) ||
                 (kind == K_STEP_M && end_cyc && mc_q == `CMAE_MC_2)) begin
      // RL16 RL17 carry kept
      flags_q <= {alu_if.fl.sign, alu_if.fl.zero, alu_if.fl.half,
                  alu_if.fl.parity, flags_q.carry};
    end
  end

  // General registers and accumulator.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) regs_q[i] <= `CMAE_BYTE_RESET;
    end else if (end_cyc && st_q == ST_FETCH && end_instr) begin
      case (kind)
        // RL2 RL19 register copy
        K_COPY_RR: regs_q[dsel] <= regs_q[ssel];
        // RL9 pair swap
        K_SWAP: begin
          regs_q[`CMAE_SEL_H] <= regs_q[`CMAE_SEL_D];
          regs_q[`CMAE_SEL_D] <= regs_q[`CMAE_SEL_H];
          regs_q[`CMAE_SEL_L] <= regs_q[`CMAE_SEL_E];
          regs_q[`CMAE_SEL_E] <= regs_q[`CMAE_SEL_L];
        end
        // RL12 register sum
        K_ARITH_R: regs_q[`CMAE_SEL_ACC] <= alu_if.res;
        K_STEP_R:  regs_q[dsel] <= alu_if.res;
        // RL18 pair increment
        K_PAIR_INC: begin
          if (psel != `CMAE_PAIR_SP) begin
            regs_q[{psel, 1'b0}] <= pair_inc[15:8];
            regs_q[{psel, 1'b1}] <= pair_inc[7:0];
          end
        end
        default: regs_q[dsel] <= regs_q[dsel];
      endcase
    end else if (end_cyc && st_q == ST_OPER) begin
      case (kind)
        K_COPY_RM, K_IMM_R: regs_q[dsel] <= mem_rdata;
        // RL5 pair bytes
        K_PAIR_IMM: begin
          if (psel != `CMAE_PAIR_SP)
            regs_q[{psel, mc_q == `CMAE_MC_2}] <= mem_rdata;
        end
        K_ACC_LD_IND: regs_q[`CMAE_SEL_ACC] <= mem_rdata;
        K_ACC_LD_DIR: begin
          if (mc_q == `CMAE_MC_4) regs_q[`CMAE_SEL_ACC] <= mem_rdata;
        end
        // RL7 low then high
        K_PTR_LD_DIR: begin
          if (mc_q == `CMAE_MC_4) regs_q[`CMAE_SEL_L] <= mem_rdata;
          if (mc_q == `CMAE_MC_5) regs_q[`CMAE_SEL_H] <= mem_rdata;
        end
        K_ARITH_M, K_ARITH_I: regs_q[`CMAE_SEL_ACC] <= alu_if.res;
        default: regs_q[dsel] <= regs_q[dsel];
      endcase
    end
  end

  // Stack pointer is reached only by pair load and pair increment.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sp_q <= `CMAE_WORD_RESET;
    end else if (psel == `CMAE_PAIR_SP && end_cyc) begin
      if (kind == K_PAIR_INC && st_q == ST_FETCH) sp_q <= pair_inc;
      if (kind == K_PAIR_IMM && st_q == ST_OPER) begin
        if (mc_q == `CMAE_MC_2) sp_q[7:0] <= mem_rdata;
        else sp_q[15:8] <= mem_rdata;
      end
    end
  end

  // Completion pulse and stop indication.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      done_q <= end_instr && kind != K_BAD;
      stop_q <= st_q == ST_STOP;
    end
  end
endmodule

// File: cmae_exec_checker.sv
// Assertions on the memory bus, flags and sequencing of the exec block.
// Assumes it is bound to the top module with its parameter handed on.
`timescale 1ns/1ps
module cmae_exec_checker #(
  parameter int STATE_DIV = 1
) (
  // Clock and reset.
  input wire logic            clk,
  input wire logic            nrst,
  // Observed outputs.
  input cmae_pkg::cmae_word_t  mem_addr_q,
  input wire logic            mem_wr_q,
  input cmae_pkg::cmae_byte_t  mem_wdata_q,
  input cmae_pkg::cmae_word_t  pc_q,
  input cmae_pkg::cmae_byte_t  regs_q [8],
  input cmae_pkg::cmae_flags_t flags_q,
  input wire logic            done_q,
  input wire logic            stop_q
);
  import cmae_pkg::*;
  // One domain only, so clock and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Flags may only move in the closing states of an instruction.
  flag_end_a: assert property ($changed(flags_q) |-> ##[0:4] done_q)
    else $error("flags changed away from an instruction end");
  // Byte fetches walk forward one address at a time.
  pc_step_a: assert property ($changed(pc_q) |->
    pc_q == $past(pc_q) + 16'h0001)
    else $error("program counter did not step by one");
  // The shortest instruction lasts four states.
  gap_min_a: assert property (done_q |=> !done_q [*3])
    else $error("instruction shorter than four states");
  // The longest instruction lasts sixteen states.
  gap_max_a: assert property (done_q |->
    ##[4:16] (done_q || stop_q))
    else $error("instruction longer than sixteen states");
  // A write strobe finds address and data already settled.
  wr_stable_a: assert property (mem_wr_q |->
    $stable(mem_addr_q) && $stable(mem_wdata_q))
    else $error("write address or data moved under the strobe");
  // Flags written with the accumulator describe the new value.
  parity_a: assert property ($changed(flags_q) && $changed(regs_q[7]) |->
    flags_q.parity == ~^regs_q[7])
    else $error("parity flag disagrees with accumulator");
  zero_flag_a: assert property ($changed(flags_q) &&
    $changed(regs_q[7]) |-> flags_q.zero == (regs_q[7] == 8'h00))
    else $error("zero flag disagrees with accumulator");
  sign_flag_a: assert property ($changed(flags_q) &&
    $changed(regs_q[7]) |-> flags_q.sign == regs_q[7][7])
    else $error("sign flag disagrees with accumulator");

  // Main scenarios reached.
  cover property (mem_wr_q);
  cover property ($rose(flags_q.carry));
  cover property ($rose(stop_q));
endmodule

bind cmae_exec cmae_exec_checker #(.STATE_DIV(STATE_DIV)) chk_u (
  .clk(clk), .nrst(nrst), .mem_addr_q(mem_addr_q), .mem_wr_q(mem_wr_q),
  .mem_wdata_q(mem_wdata_q), .pc_q(pc_q), .regs_q(regs_q),
  .flags_q(flags_q), .done_q(done_q), .stop_q(stop_q));

// File: cmae_map.svh
// Named constants of the move and arithmetic execution block.
// Assumes inclusion by the modules of the same block only.
`ifndef CMAE_MAP_SVH
`define CMAE_MAP_SVH

// Register select codes of three-bit select fields.
`define CMAE_SEL_D        3'h2
`define CMAE_SEL_E        3'h3
`define CMAE_SEL_H        3'h4
`define CMAE_SEL_L        3'h5
`define CMAE_SEL_MEM      3'h6
`define CMAE_SEL_ACC      3'h7

// Pair select codes of two-bit pair fields.
`define CMAE_PAIR_DE      2'h1
`define CMAE_PAIR_HL      2'h2
`define CMAE_PAIR_SP      2'h3

// Opcode field positions.
`define CMAE_GRP_MSB      7
`define CMAE_GRP_LSB      6
`define CMAE_DST_MSB      5
`define CMAE_DST_LSB      3
`define CMAE_SRC_MSB      2
`define CMAE_SRC_LSB      0
`define CMAE_PAIR_MSB     5
`define CMAE_PAIR_LSB     4
`define CMAE_LOAD_BIT     3
`define CMAE_WIDE_BIT     4
`define CMAE_DIRECT_BIT   5
`define CMAE_DEC_BIT      0
`define CMAE_AOP_SUB_BIT  1
`define CMAE_AOP_CY_BIT   0

// Opcode group codes and low-field codes of the misc group.
`define CMAE_GRP_COPY     2'h1
`define CMAE_GRP_ARITH    2'h2
`define CMAE_GRP_IMM      2'h3
`define CMAE_LO_PAIR_IMM  3'h1
`define CMAE_LO_XFER      3'h2
`define CMAE_LO_PAIR_INC  3'h3
`define CMAE_LO_INC       3'h4
`define CMAE_LO_DEC       3'h5
`define CMAE_LO_IMM       3'h6
`define CMAE_OP_SWAP      8'heb
`define CMAE_AOP_LAST     3'h3

// Machine cycle indices and state indices within a machine cycle.
`define CMAE_MC_1         3'd0
`define CMAE_MC_2         3'd1
`define CMAE_MC_3         3'd2
`define CMAE_MC_4         3'd3
`define CMAE_MC_5         3'd4
`define CMAE_T_FIRST      3'd0
`define CMAE_T_OPCODE     3'd2
`define CMAE_T_WRITE      3'd1
`define CMAE_T_M1_LAST    3'd3
`define CMAE_T_LONG_LAST  3'd4
`define CMAE_T_MX_LAST    3'd2

// Reset values and constants.
`define CMAE_BYTE_RESET   8'h00
`define CMAE_WORD_RESET   16'h0000
`define CMAE_BYTE_ONE     8'h01
`define CMAE_WORD_ONE     16'h0001

`endif

// File: cmae_mem_model.sv
// Behavioural memory on the far side of the exec block's bus.
// Assumes the bench loads the mem array before reset is released.
`timescale 1ns/1ps
module cmae_mem_model (
  // Clock.
  input wire logic                 clk,
  // Memory bus.
  input wire cmae_pkg::cmae_word_t addr,
  input wire logic                 rd,
  input wire logic                 wr,
  input wire cmae_pkg::cmae_byte_t wdata,
  output cmae_pkg::cmae_byte_t     rdata
);
  import cmae_pkg::*;
  cmae_byte_t mem [65536];
  cmae_byte_t last_q;
  // Unwritten bytes hold a marker so stray reads stand out.
  initial begin
    last_q = 8'h00;
    foreach (mem[i]) mem[i] = 8'hee;
  end
  // Outside a read the bus shows the inverse of the last byte, so a
  // sample taken at the wrong time cannot pass by luck.
  assign rdata = rd ? mem[addr] : ~last_q;
  // Reads are combinational; writes land on the strobe's edge.
  always @(posedge clk) begin
    if (rd) last_q <= mem[addr];
    if (wr) mem[addr] <= wdata;
  end
endmodule

// File: cmae_pkg.sv
// Types of the move and arithmetic execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package cmae_pkg;

  typedef logic [7:0]  cmae_byte_t;
  typedef logic [15:0] cmae_word_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic half;
    logic parity;
    logic carry;
  } cmae_flags_t;

  typedef enum logic [4:0] {
    K_COPY_RR, K_COPY_RM, K_COPY_MR, K_IMM_R, K_IMM_M, K_PAIR_IMM,
    K_ACC_LD_DIR, K_ACC_ST_DIR, K_PTR_LD_DIR, K_PTR_ST_DIR,
    K_ACC_LD_IND, K_ACC_ST_IND, K_SWAP, K_ARITH_R, K_ARITH_M,
    K_ARITH_I, K_STEP_R, K_STEP_M, K_PAIR_INC, K_BAD
  } cmae_kind_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_OPER, ST_STOP}
    cmae_state_t;

endpackage

// File: cmae_state_tick.sv
// Divider that makes the one-cycle state enable from the system clock.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module cmae_state_tick #(
  parameter int DIV = 1
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic nrst,
  // State enable pulse.
  output logic      tick
);
  localparam int W = $clog2(DIV + 1);

  logic [W-1:0] cnt_q;

  if (DIV < 1) begin : g_bad_div
    $error("The state divider must be at least one.");
  end

  // A registered pulse keeps the enable free of glitches.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == W'(DIV - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick  <= 1'b0;
    end
  end
endmodule

// File: test_cpu_move_and_arith_exec.sv
// Bench that runs a short program and checks every instruction end.
// Assumes the memory model and checker are compiled before it.
`timescale 1ns/1ps
module test_cpu_move_and_arith_exec;
  import cmae_pkg::*;
  logic        clk;
  logic        nrst;
  logic        run;
  cmae_word_t  mem_addr_q;
  logic        mem_rd_q;
  logic        mem_wr_q;
  cmae_byte_t  mem_wdata_q;
  cmae_byte_t  mem_rdata;
  cmae_word_t  pc_q;
  cmae_word_t  sp_q;
  cmae_byte_t  regs_q [8];
  cmae_flags_t flags_q;
  logic        done_q;
  logic        stop_q;
  int          n_fail;
  int          num_checks;
  int          cyc;
  int          last_done;
  int          lp;
  int          q_st[$];
  int          q_ix[$];
  cmae_byte_t  q_v[$];
  logic [4:0]  q_fl[$];

  cmae_exec #(.STATE_DIV(1)) dut_u (
    .clk(clk), .nrst(nrst), .run(run), .mem_addr_q(mem_addr_q),
    .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_wdata_q(mem_wdata_q),
    .mem_rdata(mem_rdata), .pc_q(pc_q), .sp_q(sp_q), .regs_q(regs_q),
    .flags_q(flags_q), .done_q(done_q), .stop_q(stop_q));
  cmae_mem_model mem_u (
    .clk(clk), .addr(mem_addr_q), .rd(mem_rd_q), .wr(mem_wr_q),
    .wdata(mem_wdata_q), .rdata(mem_rdata));

  // Clock of 5 ns.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts a comparison and reports it at once when it fails.
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Places one instruction and queues what its end must show.
  task automatic put(input cmae_byte_t op, b2, b3, input int n, st, ix,
                     input cmae_byte_t v, input logic [4:0] fl);
    mem_u.mem[lp] = op;
    if (n > 1) mem_u.mem[lp + 1] = b2;
    if (n > 2) mem_u.mem[lp + 2] = b3;
    lp += n;
    q_st.push_back(st);
    q_ix.push_back(ix);
    q_v.push_back(v);
    q_fl.push_back(fl);
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Timeout and per-instruction compares; the first gap spans start-up.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1500) begin
      n_fail++;
      give_verdict();
    end
    if (done_q === 1'b1) begin
      if (q_st.size() == 0) check(1'b0, "extra instruction end");
      else begin
        if (last_done > 0) check(cyc - last_done == q_st[0], "states");
        check(regs_q[q_ix[0]] === q_v[0], "register value");
        check(flags_q === q_fl[0], "flags");
        void'(q_st.pop_front());
        void'(q_ix.pop_front());
        void'(q_v.pop_front());
        void'(q_fl.pop_front());
      end
      last_done = cyc;
    end
  end

  initial begin
    nrst = 1'b0;
    run = 1'b0;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    last_done = 0;
    lp = 0;
    #1;
    put(8'h40, 8'h00, 8'h00, 1, 5, 0, 8'h00, 5'h00);
    put(8'h21, 8'h00, 8'h01, 3, 10, 4, 8'h01, 5'h00);
    put(8'h3e, 8'h3c, 8'h00, 2, 7, 7, 8'h3c, 5'h00);
    put(8'h06, 8'hc5, 8'h00, 2, 7, 0, 8'hc5, 5'h00);
    put(8'h48, 8'h00, 8'h00, 1, 5, 1, 8'hc5, 5'h00);
    put(8'h80, 8'h00, 8'h00, 1, 4, 7, 8'h01, 5'h05);
    put(8'h89, 8'h00, 8'h00, 1, 4, 7, 8'hc7, 5'h10);
    put(8'h36, 8'h11, 8'h00, 2, 10, 7, 8'hc7, 5'h10);
    put(8'h96, 8'h00, 8'h00, 1, 7, 7, 8'hb6, 5'h14);
    put(8'hd6, 8'hb7, 8'h00, 2, 7, 7, 8'hff, 5'h13);
    put(8'h98, 8'h00, 8'h00, 1, 4, 7, 8'h39, 5'h06);
    put(8'hde, 8'h39, 8'h00, 2, 7, 7, 8'h00, 5'h0e);
    put(8'hce, 8'hff, 8'h00, 2, 7, 7, 8'hff, 5'h12);
    put(8'h3c, 8'h00, 8'h00, 1, 5, 7, 8'h00, 5'h0e);
    put(8'h05, 8'h00, 8'h00, 1, 5, 0, 8'hc4, 5'h14);
    put(8'h34, 8'h00, 8'h00, 1, 10, 7, 8'h00, 5'h02);
    put(8'h32, 8'h23, 8'h01, 3, 13, 7, 8'h00, 5'h02);
    put(8'h3a, 8'h00, 8'h01, 3, 13, 7, 8'h12, 5'h02);
    put(8'h22, 8'h30, 8'h01, 3, 16, 5, 8'h00, 5'h02);
    put(8'h11, 8'hff, 8'h22, 3, 10, 2, 8'h22, 5'h02);
    put(8'heb, 8'h00, 8'h00, 1, 4, 4, 8'h22, 5'h02);
    put(8'h23, 8'h00, 8'h00, 1, 5, 4, 8'h23, 5'h02);
    put(8'h2a, 8'h00, 8'h01, 3, 16, 4, 8'hee, 5'h02);
    put(8'h02, 8'h00, 8'h00, 1, 7, 7, 8'h12, 5'h02);
    put(8'h5e, 8'h00, 8'h00, 1, 7, 3, 8'hee, 5'h02);
    put(8'h70, 8'h00, 8'h00, 1, 7, 0, 8'hc4, 5'h02);
    put(8'h1a, 8'h00, 8'h00, 1, 7, 7, 8'hee, 5'h02);
    put(8'h31, 8'hff, 8'h12, 3, 10, 7, 8'hee, 5'h02);
    put(8'h33, 8'h00, 8'h00, 1, 5, 7, 8'hee, 5'h02);
    mem_u.mem[lp] = 8'h76;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    run <= 1'b1;
    #1;
    check(pc_q === 16'h0000 && sp_q === 16'h0000, "reset pc or sp");
    while (stop_q !== 1'b1) @(posedge clk);
    check(q_st.size() == 0, "instructions missing");
    check(mem_u.mem[16'h0100] === 8'h12, "increment in memory");
    check(mem_u.mem[16'h0123] === 8'h00, "direct store");
    check(mem_u.mem[16'h0130] === 8'h00, "pointer store low");
    check(mem_u.mem[16'h0131] === 8'h01, "pointer store high");
    check(mem_u.mem[16'hc4c5] === 8'h12, "indirect store");
    check(mem_u.mem[16'hee12] === 8'hc4, "copy to memory");
    check(regs_q[2] === 8'h01 && regs_q[5] === 8'h12, "swap or load");
    check(sp_q === 16'h1300, "stack pair");
    give_verdict();
  end
endmodule
